/* File: shift_reg_pkg.sv */
/*
 * Shared constants and types for the four-stage universal shift register
 * and its output word FIFO.
 * Assumes a single core clock domain; no other file defines these names.
 */
package shift_reg_pkg;

   // -------------------------------------------------------------------------
   // Structure
   // -------------------------------------------------------------------------
   localparam int unsigned STAGE_COUNT = 4;   // Storage stages, first to last.
   localparam int unsigned FIFO_DEPTH  = 8;   // Words buffered on the output.

   // -------------------------------------------------------------------------
   // Reset values
   // -------------------------------------------------------------------------
   localparam logic [STAGE_COUNT-1:0] STAGE_RESET = 4'h0;   // Cleared stages.

   // -------------------------------------------------------------------------
   // Modes, coded as {upper select, lower select}
   // -------------------------------------------------------------------------
   typedef enum logic [1:0]
   {
      MODE_HOLD  = 2'h0,
      MODE_RIGHT = 2'h1,
      MODE_LEFT  = 2'h2,
      MODE_LOAD  = 2'h3
   } mode_t;

   typedef logic [STAGE_COUNT-1:0] stage_word_t;

endpackage

/* File: shift_source.sv */
/*
 * Model of the driving logic in front of the shift register: shift clock
 * pulses with mode and data set a full core cycle ahead of each rise.
 * Assumes clk is the core clock and one caller at a time runs pulse.
 */
`timescale 1ns/1ps

module shift_source
(
   input  wire logic           clk,         // Core clock.
   output logic                shift_clk,   // Shift clock pin level.
   output shift_reg_pkg::mode_t mode,       // Mode select pair.
   output logic                ser_right,   // Right serial input.
   output logic                ser_left,    // Left serial input.
   output shift_reg_pkg::stage_word_t par   // Parallel input.
);
   import shift_reg_pkg::*;

   // Idle levels at time zero.
   initial
   begin
      shift_clk = 1'b0;
      mode      = MODE_HOLD;
      ser_right = 1'b0;
      ser_left  = 1'b0;
      par       = 4'h0;
   end

   // One pulse; low_cycles of at least 1 stretches the low phase.
   // Data is inverted once the clock falls, so stale levels never pass.
   task automatic pulse(input mode_t m, input logic sr, input logic sl,
                        input stage_word_t p, input int low_cycles);
      @(posedge clk);
      #1;
      mode      = m;
      ser_right = sr;
      ser_left  = sl;
      par       = p;
      repeat (low_cycles) @(posedge clk);
      #1 shift_clk = 1'b1;
      @(posedge clk);
      #1;
      shift_clk = 1'b0;
      mode      = mode_t'(~m);
      ser_right = ~sr;
      ser_left  = ~sl;
      par       = ~p;
   endtask
endmodule

/* File: test_universal_shift_register_4bit.sv */
/*
 * Self-checking bench: a cycle model of stages and output FIFO is
 * compared with the design at every falling core edge outside reset.
 * Assumes shift_source drives the shift side; the bench drives the rest.
 */
`timescale 1ns/1ps

module test_universal_shift_register_4bit;
   import shift_reg_pkg::*;

   localparam int DEPTH = 8;

   logic        core_clk;
   logic        sys_rst;
   logic        clear_n;
   logic        word_ready;
   logic        shift_clk;
   logic        ser_right;
   logic        ser_left;
   mode_t       mode;
   stage_word_t par;
   stage_word_t stages;
   logic        edge_ready;
   logic        word_valid;
   stage_word_t word_data;
   stage_word_t cur;
   stage_word_t exp_q[$];
   logic        prev_clk;
   logic        taken;
   int          rdy_mode;
   int          fails;
   int          num_checks;

   initial core_clk = 1'b0;
   always #4 core_clk = ~core_clk;

   universal_shift_register #(.DEPTH(DEPTH)) uut
   (
      .CORE_CLK(core_clk), .SYS_RST(sys_rst), .CLEAR_N(clear_n),
      .SHIFT_CLK(shift_clk), .MODE_SELECT_UPPER(mode[1]), .MODE_SELECT_LOWER(mode[0]),
      .SERIAL_RIGHT_IN(ser_right), .SERIAL_LEFT_IN(ser_left), .PARALLEL_IN(par),
      .STAGE_FIRST_OUT(stages[0]), .STAGE_SECOND_OUT(stages[1]),
      .STAGE_THIRD_OUT(stages[2]), .STAGE_LAST_OUT(stages[3]),
      .EDGE_READY(edge_ready), .WORD_VALID(word_valid),
      .WORD_READY(word_ready), .WORD_DATA(word_data)
   );

   shift_source src
   (
      .clk(core_clk), .shift_clk(shift_clk), .mode(mode),
      .ser_right(ser_right), .ser_left(ser_left), .par(par)
   );

   // ---------------------------------------------------------------
   // Reference model
   // ---------------------------------------------------------------
   function automatic stage_word_t next_word(stage_word_t q, mode_t m, logic sr,
                                             logic sl, stage_word_t p);
      case (m)
         MODE_LOAD:  return p;
         MODE_RIGHT: return {q[2:0], sr};
         MODE_LEFT:  return {sl, q[3:1]};
         default:    return q;
      endcase
   endfunction

   // Full is judged before this edge's pop, since a pop frees room late.
   always @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         cur      = STAGE_RESET;
         prev_clk = 1'b0;
         exp_q.delete();
      end
      else
      begin
         taken = shift_clk && !prev_clk && clear_n && (mode != MODE_HOLD)
                 && (exp_q.size() < DEPTH);
         if ((exp_q.size() != 0) && word_ready)
            void'(exp_q.pop_front());
         if (!clear_n)
            cur = STAGE_RESET;
         else if (taken)
         begin
            cur = next_word(cur, mode, ser_right, ser_left, par);
            exp_q.push_back(cur);
         end
         prev_clk = shift_clk;
      end
   end

   task automatic check(input logic [3:0] seen, input logic [3:0] want, input string what);
      num_checks++;
      if (seen !== want)
      begin
         fails++;
         $display("wrong value at %0t: %s saw %h expected %h", $time, what, seen, want);
      end
   endtask

   // Outputs are settled by the falling edge.
   always @(negedge core_clk)
      if (!sys_rst)
      begin
         check(stages, clear_n ? cur : STAGE_RESET, "stages");
         check({3'h0, edge_ready}, {3'h0, exp_q.size() < DEPTH}, "room");
         check({3'h0, word_valid}, {3'h0, exp_q.size() != 0}, "valid");
         if (exp_q.size() != 0)
            check(word_data, exp_q[0], "word");
      end

   always @(posedge core_clk)
      #1 word_ready = (rdy_mode == 2) ? 1'($urandom) : (rdy_mode == 1);

   task automatic stop_test;
      $display("checks %0d, mismatches %0d", num_checks, fails);
      if ((fails == 0) && (num_checks > 0))
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   initial
   begin
      #200000;
      fails++;
      $display("wrong value at %0t: run did not finish", $time);
      stop_test();
   end

   initial
   begin
      int i;
      sys_rst    = 1'b1;
      clear_n    = 1'b1;
      word_ready = 1'b1;
      rdy_mode   = 1;
      fails      = 0;
      num_checks = 0;
      void'($urandom(17));
      repeat (3) @(posedge core_clk);
      #1 sys_rst = 1'b0;
      for (i = 0; i < 8; i++)
         src.pulse(mode_t'(i % 4), i[2], ~i[2], (i < 4) ? 4'hF : 4'h0, 1);
      $display("every mode done");
      rdy_mode = 2;
      for (i = 0; i < 300; i++)
         src.pulse(mode_t'(2'($urandom)), 1'($urandom), 1'($urandom), 4'($urandom),
                   1 + $urandom % 3);
      $display("random traffic done");
      rdy_mode = 1;
      repeat (DEPTH + 2) @(posedge core_clk);
      rdy_mode = 0;
      for (i = 0; i < DEPTH + 2; i++)
         src.pulse(MODE_LOAD, 1'b0, 1'b1, 4'(i + 1), 1);
      check({3'h0, edge_ready}, 4'h0, "full");
      rdy_mode = 1;
      repeat (DEPTH + 2) @(posedge core_clk);
      #1 check({3'h0, word_valid}, 4'h0, "drained");
      $display("fill and drain done");
      fork
         src.pulse(MODE_LOAD, 1'b1, 1'b1, 4'hF, 2);
         begin
            @(posedge core_clk);
            #1 clear_n = 1'b0;
            #1 check(stages, 4'h0, "clear");
            repeat (3) @(posedge core_clk);
            #1 clear_n = 1'b1;
         end
      join
      $display("clear done");
      rdy_mode = 0;
      src.pulse(MODE_LOAD, 1'b0, 1'b0, 4'hC, 1);
      @(posedge core_clk);
      #1 sys_rst = 1'b1;
      @(posedge core_clk);
      #1 sys_rst = 1'b0;
      src.pulse(MODE_RIGHT, 1'b1, 1'b0, 4'h0, 1);
      repeat (2) @(posedge core_clk);
      $display("second reset done");
      stop_test();
   end
endmodule

/* File: universal_shift_register.sv */
/*
 * Four-stage bidirectional universal shift register with clear, load,
 * shift right, shift left and hold, plus an output word FIFO that carries
 * every shifted or loaded register value downstream.
 * Assumes all inputs, the shift clock pin included, are synchronous to
 * CORE_CLK and that the shift clock is slower than half of it.
 */
//
// Function
// - Clear low forces all four outputs low at once, whatever else happens.
// - With clear high and shift clock idle, outputs keep their previous values.
// - Outputs change only on a rising shift clock edge, never high or falling.
// - Both selects high: rising edge loads parallel inputs into matching stages. The code refuses the edge while the FIFO is full.
// - Upper low, lower high: shift right, first stage takes right serial input. The code refuses the edge while the FIFO is full.
// - Upper high, lower low: shift left, last stage takes left serial input. The code refuses the edge while the FIFO is full.
// - Both selects low: hold all outputs regardless of clock or data.
// - Four storage stages, each driving one output, moving either direction.
`timescale 1ns/1ps

module universal_shift_register
   import shift_reg_pkg::*;
#(
   parameter int unsigned DEPTH = shift_reg_pkg::FIFO_DEPTH   // Output FIFO depth.
)
(
   input  wire logic                      CORE_CLK,            // Core clock, 125 MHz.
   input  wire logic                      SYS_RST,             // Synchronous reset, high.
   input  wire logic                      CLEAR_N,             // Asynchronous clear, low.
   input  wire logic                      SHIFT_CLK,           // Shift clock pin level.
   input  wire logic                      MODE_SELECT_UPPER,   // Upper mode select.
   input  wire logic                      MODE_SELECT_LOWER,   // Lower mode select.
   input  wire logic                      SERIAL_RIGHT_IN,     // Serial in, shift right.
   input  wire logic                      SERIAL_LEFT_IN,      // Serial in, shift left.
   input  wire shift_reg_pkg::stage_word_t PARALLEL_IN,        // Parallel data, bit 0 first.
   output logic                           STAGE_FIRST_OUT,     // First stage output.
   output logic                           STAGE_SECOND_OUT,    // Second stage output.
   output logic                           STAGE_THIRD_OUT,     // Third stage output.
   output logic                           STAGE_LAST_OUT,      // Last stage output.
   output logic                           EDGE_READY,          // Low: edges are refused.
   output logic                           WORD_VALID,          // FIFO word available.
   input  wire logic                      WORD_READY,          // Downstream takes word.
   output shift_reg_pkg::stage_word_t     WORD_DATA            // FIFO word, bit 0 first.
);
   import shift_reg_pkg::*;

   // -------------------------------------------------------------------------
   // Edge detection and mode decode
   // -------------------------------------------------------------------------
   stage_word_t stage_q;
   stage_word_t stage_d;
   logic        shift_clk_q;
   logic        shift_rise;
   logic        update;
   mode_t       mode;

   word_stream_if #(.WIDTH(STAGE_COUNT)) push_if ();
   word_stream_if #(.WIDTH(STAGE_COUNT)) pop_if ();

   assign mode       = mode_t'({MODE_SELECT_UPPER, MODE_SELECT_LOWER});
   assign shift_rise = SHIFT_CLK && !shift_clk_q;

   // Previous pin level; only a low-to-high step counts as an edge.
   always_ff @(posedge CORE_CLK)
   begin
      if (SYS_RST)
      begin
         shift_clk_q <= 1'b0;
      end
      else
      begin
         shift_clk_q <= SHIFT_CLK;
      end
   end

   // -------------------------------------------------------------------------
   // Next stage values
   // -------------------------------------------------------------------------
   // Each stage picks its neighbour, its parallel bit or itself.
   for (genvar i = 0; i < STAGE_COUNT; i++)
   begin : g_stage
      logic from_left;
      logic from_right;
      if (i == 0)
      begin : g_first
         assign from_left = SERIAL_RIGHT_IN;
      end
      else
      begin : g_mid_l
         assign from_left = stage_q[i-1];
      end
      if (i == STAGE_COUNT - 1)
      begin : g_last
         assign from_right = SERIAL_LEFT_IN;
      end
      else
      begin : g_mid_r
         assign from_right = stage_q[i+1];
      end
      always_comb
      begin
         unique case (mode)
            MODE_LOAD:  stage_d[i] = PARALLEL_IN[i];
            MODE_RIGHT: stage_d[i] = from_left;
            MODE_LEFT:  stage_d[i] = from_right;
            MODE_HOLD:  stage_d[i] = stage_q[i];
         endcase
      end
   end

   // An edge only moves data when the FIFO can take the new word; a full
   // FIFO therefore refuses edges rather than losing words downstream.
   assign update = shift_rise && CLEAR_N && (mode != MODE_HOLD) && push_if.ready;

   // -------------------------------------------------------------------------
   // Storage stages
   // -------------------------------------------------------------------------
   // Clear empties the stages; the output mask below makes it immediate.
   always_ff @(posedge CORE_CLK)
   begin
      if (SYS_RST || !CLEAR_N)
      begin
         stage_q <= STAGE_RESET;
      end
      else if (update)
      begin
         stage_q <= stage_d;
      end
   end

   // The mask costs one gate on the output path but lets clear act in the
   // same cycle instead of waiting for the next core edge.
   assign STAGE_FIRST_OUT  = CLEAR_N && stage_q[0];
   assign STAGE_SECOND_OUT = CLEAR_N && stage_q[1];
   assign STAGE_THIRD_OUT  = CLEAR_N && stage_q[2];
   assign STAGE_LAST_OUT   = CLEAR_N && stage_q[3];

   // -------------------------------------------------------------------------
   // Output word FIFO
   // -------------------------------------------------------------------------
   assign push_if.valid = update;
   assign push_if.data  = stage_d;
   assign EDGE_READY    = push_if.ready;
   assign pop_if.ready  = WORD_READY;
   assign WORD_VALID    = pop_if.valid;
   assign WORD_DATA     = pop_if.data;

   word_fifo #(.WIDTH(STAGE_COUNT), .DEPTH(DEPTH)) u_fifo
   (
      .clk   (CORE_CLK),
      .rst   (SYS_RST),
      .fill  (push_if),
      .drain (pop_if)
   );

   // -------------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------------
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (SYS_RST);

   stage_word_t outs;
   assign outs = {STAGE_LAST_OUT, STAGE_THIRD_OUT, STAGE_SECOND_OUT, STAGE_FIRST_OUT};

   property p_clear_low;
      !CLEAR_N |-> (outs == STAGE_RESET) ##1 (stage_q == STAGE_RESET);
   endproperty
   a_clear_low: assert property (p_clear_low) else $error("clear did not force outputs low");

   property p_idle_hold;
      (CLEAR_N && !shift_rise) |=> (stage_q == $past(stage_q));
   endproperty
   a_idle_hold: assert property (p_idle_hold) else $error("stages moved without an edge");

   // A reset in the previous cycle also empties the stages, so that step is
   // left out here; otherwise a mid-run reset would look like a stray update.
   property p_rise_only;
      (!$past(SYS_RST) && $past(CLEAR_N) && (stage_q != $past(stage_q)))
         |-> $past(shift_rise);
   endproperty
   a_rise_only: assert property (p_rise_only) else $error("stages changed off a rising edge");

   property p_load;
      (shift_rise && CLEAR_N && mode == MODE_LOAD && push_if.ready)
         |=> (stage_q == $past(PARALLEL_IN));
   endproperty
   a_load: assert property (p_load) else $error("parallel load wrong");

   property p_right;
      (shift_rise && CLEAR_N && mode == MODE_RIGHT && push_if.ready)
         |=> (stage_q == {$past(stage_q[2:0]), $past(SERIAL_RIGHT_IN)});
   endproperty
   a_right: assert property (p_right) else $error("shift right wrong");

   property p_left;
      (shift_rise && CLEAR_N && mode == MODE_LEFT && push_if.ready)
         |=> (stage_q == {$past(SERIAL_LEFT_IN), $past(stage_q[3:1])});
   endproperty
   a_left: assert property (p_left) else $error("shift left wrong");

   property p_hold_mode;
      (CLEAR_N && mode == MODE_HOLD) [*2] |-> (stage_q == $past(stage_q, 1));
   endproperty
   a_hold_mode: assert property (p_hold_mode) else $error("hold mode moved stages");

   property p_word_matches;
      (push_if.valid && push_if.ready) |=> (stage_q == $past(push_if.data)) && WORD_VALID;
   endproperty
   a_word_matches: assert property (p_word_matches) else $error("queued word differs");

   // A refused edge must leave the stages alone; moving them would put a
   // value on the outputs that never reaches the word stream.
   property p_full_refuse;
      (shift_rise && CLEAR_N && !push_if.ready) |=> (stage_q == $past(stage_q));
   endproperty
   a_full_refuse: assert property (p_full_refuse) else $error("refused edge moved stages");

   c_load:  cover property (update && mode == MODE_LOAD);
   c_right: cover property (update && mode == MODE_RIGHT ##[1:20] update && mode == MODE_RIGHT);
   c_left:  cover property (update && mode == MODE_LEFT);
   c_full:  cover property (shift_rise && CLEAR_N && !push_if.ready);
   c_clear: cover property (shift_rise && !CLEAR_N && mode != MODE_HOLD);

endmodule

/* File: word_fifo.sv */
/*
 * Flip-flop FIFO with valid/ready on both sides.
 * Assumes DEPTH of at least two; one clock, synchronous active-high reset.
 */
`timescale 1ns/1ps

module word_fifo
#(
   parameter int unsigned WIDTH = 4,   // Word width in bits.
   parameter int unsigned DEPTH = 8    // Number of words held.
)
(
   input  wire logic    clk,     // Core clock.
   input  wire logic    rst,     // Synchronous reset, active high.
   word_stream_if.snk   fill,    // Filling side.
   word_stream_if.src   drain    // Draining side.
);

   localparam int unsigned PW = $clog2(DEPTH);
   localparam int unsigned CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW-1:0]    wr_q;
   logic [PW-1:0]    rd_q;
   logic [CW-1:0]    count_q;
   logic             push;
   logic             pop;

   // -------------------------------------------------------------------------
   // Handshakes
   // -------------------------------------------------------------------------
   // Full and empty come straight from the count, so neither can lie.
   assign fill.ready  = (count_q != CW'(DEPTH));
   assign drain.valid = (count_q != '0);
   assign drain.data  = mem_q[rd_q];
   assign push        = fill.valid && fill.ready;
   assign pop         = drain.valid && drain.ready;

   // Storage is written only on an accepted push.
   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem_q[wr_q] <= fill.data;
      end
   end

   // Pointers wrap explicitly so a depth that is not a power of two works.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         wr_q <= '0;
         rd_q <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_q <= (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
         end
         if (pop)
         begin
            rd_q <= (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
         end
      end
   end

   // Occupancy count.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         count_q <= '0;
      end
      else if (push && !pop)
      begin
         count_q <= count_q + 1'b1;
      end
      else if (pop && !push)
      begin
         count_q <= count_q - 1'b1;
      end
   end

endmodule

/* File: word_stream_if.sv */
/*
 * Valid/ready word stream used between the shift register and its FIFO.
 * Assumes source and sink share one clock.
 */
`timescale 1ns/1ps

interface word_stream_if
#(
   parameter int unsigned WIDTH = 4   // Word width in bits.
);
   logic             valid;
   logic             ready;
   logic [WIDTH-1:0] data;

   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface
